// *** logic/sdra_top.sv ***
// Notes on behaviour
// - activate another bank while one reads
// - read takes column, bank, auto-precharge choice
// - first data cas_latency clocks after read
// - data lines float when burst ends
// - full-page burst wraps to column zero
// - new read cuts or extends burst seamlessly
// - reads accepted every clock, any open bank
// - every write floats data; an unmasked one during a read sets wr_invalid
// - burst terminate cuts reads, timed early
// - activate takes bank and row inputs
// - precharge_select_bit picks auto precharge per command
// - burst terminate leaves row open
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sdra_top #(
	parameter int DQ_W = sdra_pkg::DQ_W,
	parameter int COL_W = sdra_pkg::COL_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire sdra_pkg::sdra_pins_t pins,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int MEM_AW = COL_W + 2;

	// ------------------------------------------------
	// command decode
	// ------------------------------------------------
	sdra_pkg::sdra_cmd_t cmd;
	sdra_pkg::sdra_rd_state_t state;
	logic [sdra_pkg::NBANK-1:0] bank_open;
	logic [sdra_pkg::NBANK-1:0][sdra_pkg::ROW_W-1:0] open_row;
	logic [3:0] cfg;
	logic [1:0] rd_bank;
	logic [COL_W-1:0] rd_col;
	logic [COL_W:0] rd_left;
	logic rd_full;
	logic rd_ap;
	logic st0_v;
	logic [DQ_W-1:0] st0_d;
	logic dqm_q;
	logic wr_invalid;
	logic [MEM_AW-1:0] maddr;
	logic [DQ_W-1:0] mem [2**MEM_AW];

	assign cmd = sdra_pkg::sdra_decode(pins);
	wire [1:0] ba = {pins.bank_select_high, pins.bank_select_low};
	wire is_act = cmd == sdra_pkg::CMD_ACT;
	wire is_rd = cmd == sdra_pkg::CMD_RD;
	wire is_wr = cmd == sdra_pkg::CMD_WR;
	wire is_bst = cmd == sdra_pkg::CMD_BST;
	wire is_pre = cmd == sdra_pkg::CMD_PRE;
	wire pre_all = pins.addr[sdra_pkg::PRE_SEL_BIT];
	wire cl3 = cfg[sdra_pkg::CFG_CL_BIT];
	wire [2:0] bl_code = cfg[sdra_pkg::CFG_BL_LSB +: 3];
	wire [COL_W-1:0] rd_col_in = pins.addr[COL_W-1:0];
	// a read to an idle bank is ignored
	wire rd_go = is_rd && bank_open[ba];
	wire bursting = state == sdra_pkg::RD_BURST;
	wire stop_pre = is_pre && (pre_all || ba == rd_bank) && bursting;
	wire last = bursting && !rd_full && rd_left == (COL_W+1)'(1);
	wire ap_close = last && rd_ap;
	wire stop = is_wr || is_bst || stop_pre || last;
	wire [DQ_W-1:0] mem_rd = mem[{rd_bank, rd_col}];
	wire [sdra_pkg::NBANK-1:0] pre_mask = is_pre ?
		(pre_all ? '1 : sdra_pkg::sdra_onehot(ba)) : '0;
	wire [sdra_pkg::NBANK-1:0] close_mask = pre_mask |
		(ap_close ? sdra_pkg::sdra_onehot(rd_bank) : '0);

	sdra_bank #(.ROW_W(sdra_pkg::ROW_W)) u_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.act(is_act),
		.act_bank(ba),
		.act_row(pins.addr),
		.close_mask(close_mask),
		.bank_open(bank_open),
		.open_row(open_row)
	);

	// ------------------------------------------------
	// read burst engine
	// ------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= sdra_pkg::RD_IDLE;
			rd_bank <= 2'h0;
			rd_col <= '0;
			rd_left <= '0;
			rd_full <= 1'b0;
			rd_ap <= 1'b0;
		end else if (rd_go) begin
			state <= sdra_pkg::RD_BURST;
			rd_bank <= ba;
			rd_col <= rd_col_in;
			rd_left <= sdra_pkg::sdra_bl_len(bl_code);
			rd_full <= bl_code == sdra_pkg::BL_FULL;
			// auto precharge never applies to a full page
			rd_ap <= pins.addr[sdra_pkg::PRE_SEL_BIT] && bl_code != sdra_pkg::BL_FULL;
		end else if (stop) begin
			state <= sdra_pkg::RD_IDLE;
		end else if (bursting) begin
			rd_col <= rd_col + COL_W'(1);
			rd_left <= rd_left - (COL_W+1)'(1);
		end
	end

	// ------------------------------------------------
	// output pipeline: one stage per extra latency clock
	// ------------------------------------------------
	wire src_v = cl3 ? st0_v : bursting;
	wire [DQ_W-1:0] src_d = cl3 ? st0_d : mem_rd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st0_v <= 1'b0;
			st0_d <= '0;
			dqm_q <= 1'b0;
			dq_out <= '0;
			dq_oe <= 1'b0;
		end else begin
			st0_v <= bursting && !is_wr;
			st0_d <= mem_rd;
			dqm_q <= pins.dqm;
			dq_out <= src_d;
			// mask sampled two edges ahead of the data edge
			dq_oe <= src_v && !dqm_q && !is_wr;
		end
	end

	// ------------------------------------------------
	// register slave
	// ------------------------------------------------
	wire wr_fire = awready;
	wire wr_hit = awaddr == sdra_pkg::REG_CFG || awaddr == sdra_pkg::REG_STAT ||
		awaddr == sdra_pkg::REG_MADDR || awaddr == sdra_pkg::REG_MDATA;
	wire rd_hit = araddr == sdra_pkg::REG_CFG || araddr == sdra_pkg::REG_STAT ||
		araddr == sdra_pkg::REG_MADDR || araddr == sdra_pkg::REG_MDATA;
	wire lane0 = wstrb[0];
	wire inv_set = is_wr && !dqm_q && (bursting || st0_v || dq_oe);
	wire inv_clr = wr_fire && lane0 && awaddr == sdra_pkg::REG_STAT &&
		wdata[sdra_pkg::STAT_INV_BIT];
	wire [31:0] stat_word = 32'({wr_invalid, bursting, bank_open});
	wire [31:0] rd_mux = araddr == sdra_pkg::REG_CFG ? 32'(cfg) :
		araddr == sdra_pkg::REG_STAT ? stat_word :
		araddr == sdra_pkg::REG_MADDR ? 32'(maddr) :
		araddr == sdra_pkg::REG_MDATA ? 32'(mem[maddr]) : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= sdra_pkg::RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= sdra_pkg::RESP_OKAY;
			rdata <= 32'h0;
		end else begin
			// both channels taken together; simple, costs nothing for this master
			awready <= !awready && awvalid && wvalid && !bvalid;
			wready <= !awready && awvalid && wvalid && !bvalid;
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? sdra_pkg::RESP_OKAY : sdra_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			arready <= !arready && arvalid && !rvalid;
			if (arready) begin
				rvalid <= 1'b1;
				rdata <= rd_mux;
				rresp <= rd_hit ? sdra_pkg::RESP_OKAY : sdra_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= sdra_pkg::CFG_RESET;
			maddr <= '0;
			wr_invalid <= 1'b0;
		end else begin
			// a new fault in the clearing cycle is kept
			wr_invalid <= inv_set || (wr_invalid && !inv_clr);
			if (wr_fire && lane0 && awaddr == sdra_pkg::REG_CFG) begin
				cfg <= wdata[3:0];
			end
			if (wr_fire && lane0 && awaddr == sdra_pkg::REG_MADDR) begin
				maddr <= wdata[MEM_AW-1:0];
			end else if (wr_fire && lane0 && awaddr == sdra_pkg::REG_MDATA) begin
				maddr <= maddr + MEM_AW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (wr_fire && lane0 && awaddr == sdra_pkg::REG_MDATA) begin
			mem[maddr] <= wdata[DQ_W-1:0];
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_float_idle: assert property (!bursting && !st0_v |=> !dq_oe)
		else $error("data driven with no burst");
	a_cl2_first: assert property (rd_go && !cl3 && !pins.dqm ##1 !is_wr && !cl3 |=> dq_oe)
		else $error("latency two data missing");
	a_cl3_first: assert property (rd_go && cl3 ##1 (!is_wr && !pins.dqm && cl3)
		##1 (!is_wr && cl3) |=> dq_oe)
		else $error("latency three data missing");
	a_write_float: assert property (is_wr |=> !dq_oe [*2])
		else $error("data driven after write");
	a_write_invalid: assert property (is_wr && !dqm_q && bursting |=> wr_invalid)
		else $error("unmasked truncating write not flagged");
	a_auto_close: assert property (ap_close && !is_act |=> !bank_open[$past(rd_bank)])
		else $error("auto precharge left row open");
	a_term_row: assert property (is_bst && !ap_close |=> bank_open == $past(bank_open))
		else $error("terminate changed bank state");
	a_term_stop: assert property (is_bst |=> !bursting)
		else $error("burst continued after terminate");
	a_page_wrap: assert property (bursting && rd_full && rd_col == '1 && !stop && !rd_go
		|=> rd_col == '0)
		else $error("full page did not wrap");
	a_read_start: assert property (rd_go |=> bursting && rd_col == $past(rd_col_in))
		else $error("read not restarted at column");
	a_act_open: assert property (is_act |=> bank_open[$past(ba)] &&
		open_row[$past(ba)] == $past(pins.addr))
		else $error("activate did not open row");
	a_idle_reject: assert property (is_rd && !bank_open[ba] && !bursting |=> !bursting)
		else $error("read to idle bank accepted");

	c_back_to_back: cover property (rd_go ##1 rd_go);
	c_terminate: cover property (bursting ##1 is_bst);
	c_wrap: cover property (bursting && rd_full && rd_col == '1);
	c_act_during_read: cover property (bursting && is_act);
endmodule

// *** logic/sdra_bank.sv ***
`timescale 1ns/1ps
package sdra_pkg;
	localparam int DQ_W = 16;
	localparam int COL_W = 8;
	localparam int ROW_W = 12;
	localparam int NBANK = 4;
	localparam int PRE_SEL_BIT = 10;
	localparam int CFG_CL_BIT = 0;
	localparam int CFG_BL_LSB = 1;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam int STAT_ACT_BIT = 4;
	localparam int STAT_INV_BIT = 5;
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_MADDR = 8'h08;
	localparam logic [7:0] REG_MDATA = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic bank_select_high;
		logic bank_select_low;
		logic [ROW_W-1:0] addr;
		logic dqm;
	} sdra_pins_t;

	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_OTHER
	} sdra_cmd_t;

	typedef enum logic {RD_IDLE, RD_BURST} sdra_rd_state_t;

	function automatic sdra_cmd_t sdra_decode(sdra_pins_t p);
		sdra_cmd_t c;
		c = CMD_OTHER;
		if (p.cs_n) begin
			c = CMD_NOP;
		end else begin
			unique case ({p.ras_n, p.cas_n, p.we_n})
				3'h7: c = CMD_NOP;
				3'h3: c = CMD_ACT;
				3'h5: c = CMD_RD;
				3'h4: c = CMD_WR;
				3'h6: c = CMD_BST;
				3'h2: c = CMD_PRE;
				default: c = CMD_OTHER;
			endcase
		end
		return c;
	endfunction

	function automatic logic [NBANK-1:0] sdra_onehot(logic [1:0] b);
		return NBANK'(1) << b;
	endfunction

	function automatic logic [COL_W:0] sdra_bl_len(logic [2:0] code);
		return (COL_W+1)'(1) << code;
	endfunction
endpackage

module sdra_bank #(
	parameter int ROW_W = sdra_pkg::ROW_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic act,
	input wire logic [1:0] act_bank,
	input wire logic [ROW_W-1:0] act_row,
	input wire logic [sdra_pkg::NBANK-1:0] close_mask,
	output logic [sdra_pkg::NBANK-1:0] bank_open,
	output logic [sdra_pkg::NBANK-1:0][ROW_W-1:0] open_row
);
	wire [sdra_pkg::NBANK-1:0] act_mask = act ? sdra_pkg::sdra_onehot(act_bank) : '0;

	// each bank keeps its own state so commands to other banks interleave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_open <= '0;
		end else begin
			bank_open <= (bank_open & ~close_mask) | act_mask;
		end
	end

	always_ff @(posedge aclk) begin
		if (act) begin
			open_row[act_bank] <= act_row;
		end
	end
endmodule

// *** dv/sdra_ctl_model.sv ***
`timescale 1ns/1ps
module sdra_ctl_model (
	input wire logic aclk,
	output sdra_pkg::sdra_pins_t pins
);
	// ----------
	// command driver
	// ----------
	initial pins = '1;
	task automatic cmd(input sdra_pkg::sdra_cmd_t c, input logic [1:0] b, input logic [11:0] a,
		input logic m);
		logic [2:0] rcw;
		case (c)
			sdra_pkg::CMD_ACT: rcw = 3'h3;
			sdra_pkg::CMD_RD: rcw = 3'h5;
			sdra_pkg::CMD_WR: rcw = 3'h4;
			sdra_pkg::CMD_BST: rcw = 3'h6;
			sdra_pkg::CMD_PRE: rcw = 3'h2;
			default: rcw = 3'h7;
		endcase
		@(posedge aclk);
		pins <= '{cs_n: 1'b0, ras_n: rcw[2], cas_n: rcw[1], we_n: rcw[0],
			bank_select_high: b[1], bank_select_low: b[0], addr: a, dqm: m};
	endtask
	// nop address lines wander so a stale value never passes for a held one
	task automatic idle(input int n, input logic m);
		for (int i = 0; i < n; i++)
			cmd(sdra_pkg::CMD_NOP, 2'(i), 12'(i * 37), m);
	endtask
endmodule

// *** dv/sdra_top_tb.sv ***
`timescale 1ns/1ps
module sdra_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	sdra_pkg::sdra_pins_t pins;
	logic [15:0] dq_out;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic dq_oe, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] want[$];
	int miscompares = 0, n_compared = 0;
	always #25 aclk = ~aclk;
	sdra_ctl_model ctl_u (.aclk(aclk), .pins(pins));
	sdra_top dut_u (.aclk(aclk), .aresetn(aresetn), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	// ----------
	// tasks
	// ----------
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
	endtask
	task automatic st(input logic [5:0] e);
		rd_reg(sdra_pkg::REG_STAT);
		check(rd, 32'(e), "status");
	endtask
	function automatic logic [15:0] mw(input logic [1:0] b, input logic [7:0] c);
		return {6'h2b, b, c};
	endfunction
	// lead counts edges from the fork, one more than the latency
	task automatic chk_burst(input int lead);
		repeat (lead) @(posedge aclk);
		foreach (want[i]) begin
			#1;
			check(32'(dq_oe), 32'h1, "dq_oe");
			check(32'(dq_out), 32'(want[i]), "dq_out");
			@(posedge aclk);
		end
		#1;
		check(32'(dq_oe), 32'h0, "dq_oe idle");
		want.delete();
	endtask
	// ----------
	// tests
	// ----------
	initial begin
		#400000;
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(sdra_pkg::REG_CFG);
		check(rd, 32'(sdra_pkg::CFG_RESET), "cfg");
		st(6'h00);
		rd_reg(8'h10);
		check(32'(resp), 32'(sdra_pkg::RESP_SLVERR), "rresp");
		check(rd, 32'h0, "rdata unmapped");
		wr(8'h10, 32'h1);
		check(32'(resp), 32'(sdra_pkg::RESP_SLVERR), "bresp");
		wr(sdra_pkg::REG_MADDR, 32'h0);
		for (int i = 0; i < 512; i++) wr(sdra_pkg::REG_MDATA, 32'(mw(2'(i / 256), 8'(i))));
		check(32'(resp), 32'(sdra_pkg::RESP_OKAY), "bresp");
		$display("registers done");
		wr(sdra_pkg::REG_CFG, 32'h4);
		fork
			begin
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h2, 12'h000, 1'b0);
				ctl_u.idle(6, 1'b0);
			end
			chk_burst(3);
		join
		ctl_u.cmd(sdra_pkg::CMD_ACT, 2'h0, 12'h123, 1'b0);
		ctl_u.idle(3, 1'b0);
		for (int i = 5; i < 9; i++) want.push_back(mw(2'h0, 8'(i)));
		fork
			begin
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, 12'h005, 1'b0);
				ctl_u.cmd(sdra_pkg::CMD_ACT, 2'h1, 12'h077, 1'b0);
				ctl_u.idle(8, 1'b0);
			end
			chk_burst(3);
		join
		st(6'h03);
		$display("activate done");
		wr(sdra_pkg::REG_CFG, 32'hf);
		for (int i = 254; i < 258; i++) want.push_back(mw(2'h0, 8'(i)));
		fork
			begin
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, 12'h0fe, 1'b0);
				ctl_u.idle(3, 1'b0);
				ctl_u.cmd(sdra_pkg::CMD_BST, 2'h0, 12'h000, 1'b0);
				ctl_u.idle(6, 1'b0);
			end
			chk_burst(4);
		join
		st(6'h03);
		$display("full page done");
		wr(sdra_pkg::REG_CFG, 32'h2);
		want = '{mw(2'h0, 8'h0a), mw(2'h0, 8'h0b), mw(2'h1, 8'h14), mw(2'h1, 8'h28),
			mw(2'h0, 8'h32), mw(2'h0, 8'h33)};
		fork
			begin
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, 12'h00a, 1'b0);
				ctl_u.idle(1, 1'b0);
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h1, 12'h014, 1'b0);
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h1, 12'h028, 1'b0);
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, 12'h032, 1'b0);
				ctl_u.idle(6, 1'b0);
			end
			chk_burst(3);
		join
		$display("chaining done");
		wr(sdra_pkg::REG_CFG, 32'he);
		for (int k = 0; k < 2; k++) begin
			want = '{mw(2'h0, 8'h00), mw(2'h0, 8'h01), mw(2'h0, 8'h02)};
			fork
				begin
					ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, 12'h000, 1'b0);
					ctl_u.idle(2, 1'b0);
					ctl_u.cmd(sdra_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1);
					ctl_u.cmd(sdra_pkg::CMD_NOP, 2'h0, 12'h000, k == 0);
					ctl_u.cmd(sdra_pkg::CMD_WR, 2'h0, 12'h000, 1'b0);
					ctl_u.idle(4, 1'b0);
				end
				chk_burst(3);
			join
			st({k[0], 5'h03});
			wr(sdra_pkg::REG_STAT, 32'h20);
		end
		st(6'h03);
		$display("write cut done");
		wr(sdra_pkg::REG_CFG, 32'h4);
		for (int k = 0; k < 2; k++) begin
			for (int i = 8; i < 12; i++) want.push_back(mw(2'h0, 8'(i)));
			fork
				begin
					ctl_u.cmd(sdra_pkg::CMD_RD, 2'h0, k ? 12'h008 : 12'h408, 1'b0);
					ctl_u.idle(3, 1'b0);
					ctl_u.cmd(k ? sdra_pkg::CMD_PRE : sdra_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0);
					ctl_u.idle(4, 1'b0);
				end
				chk_burst(3);
			join
			st(6'h02);
			ctl_u.cmd(sdra_pkg::CMD_ACT, 2'h0, 12'h123, 1'b0);
			ctl_u.idle(3, 1'b0);
		end
		$display("precharge done");
		wr(sdra_pkg::REG_CFG, 32'h7);
		for (int i = 32; i < 40; i++) want.push_back(mw(2'h1, 8'(i)));
		fork
			begin
				ctl_u.cmd(sdra_pkg::CMD_RD, 2'h1, 12'h420, 1'b0);
				ctl_u.idle(12, 1'b0);
			end
			chk_burst(4);
		join
		st(6'h01);
		ctl_u.cmd(sdra_pkg::CMD_PRE, 2'h3, 12'h400, 1'b0);
		ctl_u.idle(2, 1'b0);
		st(6'h00);
		$display("burst eight done");
		end_sim();
	end
endmodule
